//--- pkg/poc_pkg.sv
package poc_pkg;
  localparam int CH_NUM = 4;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_CW_LIMIT_BIT = 8;
  localparam int CTRL_CCW_LIMIT_BIT = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam int BLOCK_OP_MAX_WORDS = 99;
  localparam int CLK_HZ = 100_000_000;
  localparam logic [27:0] CLK_HZ_W = 28'h5f5_e100;
  localparam int CTRL_CYCLE_US = 1000;
  localparam int CTRL_CYCLE_CYCLES = CTRL_CYCLE_US * (CLK_HZ / 1_000_000);
  localparam logic [19:0] CREEP_HZ = 20'h0_03e8;
  localparam int FREQ_W = 20;

  typedef enum logic [2:0] {
    OP_STOP = 3'b000,
    OP_CONST_JOG = 3'b001,
    OP_RAMP_JOG = 3'b010,
    OP_HOME_SEARCH = 3'b011,
    OP_ORIGIN_RETURN = 3'b100,
    OP_POS_LOAD = 3'b101,
    OP_POS_READ = 3'b110,
    OP_INT_FEED = 3'b111
  } poc_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_SEARCH = 3'b010,
    ST_CREEP = 3'b011,
    ST_RETURN = 3'b100,
    ST_FEED_WAIT = 3'b101,
    ST_FEED = 3'b110,
    ST_STOP = 3'b111
  } poc_state_e;
endpackage : poc_pkg

//--- core/poc_sync.sv
`timescale 1ns/10ps
module poc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : poc_sync

//--- core/poc_pulse_gen.sv
`timescale 1ns/10ps
module poc_pulse_gen (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // rate
  input wire logic run_in,
  input wire logic [19:0] freq_in,
  // pulse
  output logic pulse_out,
  output logic step_out
);
  logic [27:0] acc_q;
  logic [27:0] acc_d;
  logic pulse_q;
  logic pulse_d;
  logic step_q;
  logic step_d;
  logic [27:0] sum;

  // two toggles per period, so the accumulator steps by twice the rate
  always_comb begin
    sum = acc_q + {7'h00, freq_in, 1'b0};
    acc_d = acc_q;
    pulse_d = pulse_q;
    step_d = 1'b0;
    if (!run_in) begin
      acc_d = '0;
      pulse_d = 1'b0;
    end else if (sum >= poc_pkg::CLK_HZ_W) begin
      acc_d = sum - poc_pkg::CLK_HZ_W;
      pulse_d = ~pulse_q;
      step_d = ~pulse_q;
    end else begin
      acc_d = sum;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= '0;
      pulse_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      pulse_q <= pulse_d;
      step_q <= step_d;
    end
  end

  assign pulse_out = pulse_q;
  assign step_out = step_q;
endmodule : poc_pulse_gen

//--- core/poc_top.sv
`timescale 1ns/10ps
module poc_top #(
  parameter int CYCLE_CYCLES = poc_pkg::CTRL_CYCLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // control words
  input wire logic ctrl_wr_in,
  input wire logic [1:0] ctrl_wr_sel_in,
  input wire logic [15:0] ctrl_wr_data_in,
  input wire logic [1:0] ctrl_rd_sel_in,
  output logic [15:0] ctrl_rd_data_out,
  // commands
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_chan_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic [19:0] cmd_freq_in,
  input wire logic [19:0] cmd_accel_in,
  input wire logic [31:0] cmd_value_in,
  input wire logic cmd_cw_in,
  input wire logic block_op_busy_in,
  // position read answer
  output logic pos_rd_valid_out,
  output logic [31:0] pos_rd_data_out,
  // pins
  input wire logic [3:0] origin_in,
  input wire logic [3:0] origin_prox_in,
  input wire logic [3:0] feed_int_in,
  output logic [3:0] pulse_out,
  output logic [3:0] dir_out,
  // status
  output logic [3:0] busy_out,
  output logic [3:0] origin_defined_out
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [11:0] pins_sync;
  logic [11:0] pins_prev_q;
  logic [11:0] pins_rise;
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  logic tick_q;
  logic tick_d;
  logic [15:0] ctrl_q [poc_pkg::CH_NUM];
  logic [15:0] ctrl_rd_q;
  logic [15:0] ctrl_rd_d;
  logic pos_rd_valid_q;
  logic pos_rd_valid_d;
  logic [31:0] pos_rd_q;
  logic [31:0] pos_rd_d;
  logic [31:0] pos_w [poc_pkg::CH_NUM];

  // ramp one controller-cycle step toward target; zero step jumps at once
  function automatic logic [19:0] ramp_step(input logic [19:0] cur, input logic [19:0] tgt,
                                            input logic [19:0] step);
    logic [20:0] up;
    ramp_step = tgt;
    up = {1'b0, cur} + {1'b0, step};
    if (step != 20'h0_0000) begin
      if (cur < tgt) begin
        ramp_step = (up >= {1'b0, tgt}) ? tgt : up[19:0];
      end else if (cur > tgt) begin
        ramp_step = ((cur - tgt) <= step) ? tgt : cur - step;
      end
    end
  endfunction : ramp_step

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  poc_sync #(
    .WIDTH(12)
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .async_in({feed_int_in, origin_prox_in, origin_in}),
    .sync_out(pins_sync)
  );
  assign pins_rise = pins_sync & ~pins_prev_q;

  // controller cycle tick and shared answers
  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    if (tick_cnt_q >= 32'(CYCLE_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      tick_d = 1'b1;
    end
    ctrl_rd_d = ctrl_q[ctrl_rd_sel_in];
    pos_rd_valid_d = cmd_valid_in && (cmd_op_in == poc_pkg::OP_POS_READ);
    pos_rd_d = pos_rd_q;
    if (pos_rd_valid_d) begin
      pos_rd_d = pos_w[cmd_chan_in];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
      pins_prev_q <= 12'h000;
      ctrl_rd_q <= poc_pkg::CTRL_RESET;
      pos_rd_valid_q <= 1'b0;
      pos_rd_q <= poc_pkg::POS_RESET;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      pins_prev_q <= pins_sync;
      ctrl_rd_q <= ctrl_rd_d;
      pos_rd_valid_q <= pos_rd_valid_d;
      pos_rd_q <= pos_rd_d;
    end
  end

  assign ctrl_rd_data_out = ctrl_rd_q;
  assign pos_rd_valid_out = pos_rd_valid_q;
  assign pos_rd_data_out = pos_rd_q;

  for (genvar i = 0; i < poc_pkg::CH_NUM; i++) begin : g_ch
    poc_pkg::poc_state_e st_q;
    poc_pkg::poc_state_e st_d;
    logic [15:0] ctrl_d;
    logic [19:0] freq_q;
    logic [19:0] freq_d;
    logic [19:0] tgt_q;
    logic [19:0] tgt_d;
    logic [19:0] accel_q;
    logic [19:0] accel_d;
    logic [31:0] pos_q;
    logic [31:0] pos_d;
    logic [31:0] remain_q;
    logic [31:0] remain_d;
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic dir_q;
    logic dir_d;
    logic org_q;
    logic org_d;
    logic clr_prev_q;
    logic clr_prev_d;
    logic busy_q;
    logic busy_d;
    logic run;
    logic step;
    logic hit;
    logic limit_hit;

    assign run = (st_q != poc_pkg::ST_IDLE) && (freq_q != 20'h0_0000) && !block_op_busy_in;
    assign hit = cmd_valid_in && (cmd_chan_in == 2'(i));
    // limit bits copied in by software
    assign limit_hit = dir_q ? ctrl_q[i][poc_pkg::CTRL_CW_LIMIT_BIT]
                             : ctrl_q[i][poc_pkg::CTRL_CCW_LIMIT_BIT];

    poc_pulse_gen u_gen (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .run_in(run),
      .freq_in(freq_q),
      .pulse_out(pulse_out[i]),
      .step_out(step)
    );

    always_comb begin
      st_d = st_q;
      ctrl_d = ctrl_q[i];
      freq_d = freq_q;
      tgt_d = tgt_q;
      accel_d = accel_q;
      pos_d = pos_q;
      remain_d = remain_q;
      count_d = count_q;
      dir_d = dir_q;
      org_d = org_q;
      clr_prev_d = clr_prev_q;
      if (ctrl_wr_in && (ctrl_wr_sel_in == 2'(i))) begin
        ctrl_d = ctrl_wr_data_in;
      end
      if (step) begin
        pos_d = dir_q ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
        if (remain_q != 32'h0000_0000) begin
          remain_d = remain_q - 32'h0000_0001;
        end
      end
      if (tick_q) begin
        clr_prev_d = ctrl_q[i][poc_pkg::CTRL_CLEAR_BIT];
        if (ctrl_q[i][poc_pkg::CTRL_CLEAR_BIT] && !clr_prev_q) begin
          if (!busy_q) begin
            pos_d = poc_pkg::POS_RESET;
          end
        end
      end
      case (st_q)
        poc_pkg::ST_IDLE: begin
          freq_d = 20'h0_0000;
        end
        poc_pkg::ST_RUN: begin
          if (tick_q) freq_d = ramp_step(freq_q, tgt_q, accel_q);
        end
        poc_pkg::ST_SEARCH: begin
          if (tick_q) freq_d = ramp_step(freq_q, tgt_q, accel_q);
          if (pins_rise[4 + i]) begin
            tgt_d = poc_pkg::CREEP_HZ;
            st_d = poc_pkg::ST_CREEP;
          end
        end
        poc_pkg::ST_CREEP: begin
          if (tick_q) freq_d = ramp_step(freq_q, tgt_q, accel_q);
          if (pins_rise[i]) begin
            pos_d = poc_pkg::POS_RESET;
            org_d = 1'b1;
            freq_d = 20'h0_0000;
            st_d = poc_pkg::ST_IDLE;
          end
        end
        poc_pkg::ST_RETURN: begin
          if (tick_q) freq_d = ramp_step(freq_q, tgt_q, accel_q);
          if (remain_d == 32'h0000_0000) begin
            freq_d = 20'h0_0000;
            st_d = poc_pkg::ST_IDLE;
          end
        end
        poc_pkg::ST_FEED_WAIT: begin
          if (tick_q) freq_d = ramp_step(freq_q, tgt_q, accel_q);
          if (pins_rise[8 + i]) begin
            remain_d = count_q;
            st_d = poc_pkg::ST_FEED;
          end
        end
        poc_pkg::ST_FEED: begin
          // slow down once fewer pulses remain than the current rate
          if (tick_q) begin
            if (remain_q < {12'h000, freq_q}) begin
              freq_d = ramp_step(freq_q, poc_pkg::CREEP_HZ, accel_q);
            end else begin
              freq_d = ramp_step(freq_q, tgt_q, accel_q);
            end
          end
          if (remain_d == 32'h0000_0000) begin
            freq_d = 20'h0_0000;
            st_d = poc_pkg::ST_IDLE;
          end
        end
        poc_pkg::ST_STOP: begin
          if (tick_q) freq_d = ramp_step(freq_q, 20'h0_0000, accel_q);
          if (freq_q == 20'h0_0000) st_d = poc_pkg::ST_IDLE;
        end
        default: begin
          st_d = poc_pkg::ST_IDLE;
        end
      endcase
      // a limit in the travel direction stops at once, no ramp
      if ((st_q != poc_pkg::ST_IDLE) && limit_hit) begin
        freq_d = 20'h0_0000;
        st_d = poc_pkg::ST_IDLE;
      end
      if (hit) begin
        case (cmd_op_in)
          poc_pkg::OP_STOP: begin
            if (st_q != poc_pkg::ST_IDLE) st_d = poc_pkg::ST_STOP;
          end
          poc_pkg::OP_CONST_JOG: begin
            tgt_d = cmd_freq_in;
            freq_d = cmd_freq_in;
            accel_d = 20'h0_0000;
            dir_d = cmd_cw_in;
            st_d = poc_pkg::ST_RUN;
          end
          poc_pkg::OP_RAMP_JOG: begin
            tgt_d = cmd_freq_in;
            accel_d = cmd_accel_in;
            dir_d = cmd_cw_in;
            st_d = poc_pkg::ST_RUN;
          end
          poc_pkg::OP_HOME_SEARCH: begin
            tgt_d = cmd_freq_in;
            accel_d = cmd_accel_in;
            dir_d = cmd_cw_in;
            st_d = poc_pkg::ST_SEARCH;
          end
          poc_pkg::OP_ORIGIN_RETURN: begin
            if (org_q && (pos_q != 32'h0000_0000)) begin
              dir_d = pos_q[31];
              remain_d = pos_q[31] ? (~pos_q + 32'h0000_0001) : pos_q;
              tgt_d = cmd_freq_in;
              accel_d = cmd_accel_in;
              st_d = poc_pkg::ST_RETURN;
            end
          end
          poc_pkg::OP_POS_LOAD: begin
            pos_d = cmd_value_in;
            org_d = 1'b1;
          end
          poc_pkg::OP_INT_FEED: begin
            tgt_d = cmd_freq_in;
            accel_d = cmd_accel_in;
            dir_d = cmd_cw_in;
            count_d = cmd_value_in;
            st_d = poc_pkg::ST_FEED_WAIT;
          end
          default: begin
          end
        endcase
      end
      busy_d = (st_d != poc_pkg::ST_IDLE);
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        st_q <= poc_pkg::ST_IDLE;
        ctrl_q[i] <= poc_pkg::CTRL_RESET;
        freq_q <= 20'h0_0000;
        tgt_q <= 20'h0_0000;
        accel_q <= 20'h0_0000;
        pos_q <= poc_pkg::POS_RESET;
        remain_q <= 32'h0000_0000;
        count_q <= 32'h0000_0000;
        dir_q <= 1'b0;
        org_q <= 1'b0;
        clr_prev_q <= 1'b0;
        busy_q <= 1'b0;
      end else begin
        st_q <= st_d;
        ctrl_q[i] <= ctrl_d;
        freq_q <= freq_d;
        tgt_q <= tgt_d;
        accel_q <= accel_d;
        pos_q <= pos_d;
        remain_q <= remain_d;
        count_q <= count_d;
        dir_q <= dir_d;
        org_q <= org_d;
        clr_prev_q <= clr_prev_d;
        busy_q <= busy_d;
      end
    end

    assign pos_w[i] = pos_q;
    assign dir_out[i] = dir_q;
    assign busy_out[i] = busy_q;
    assign origin_defined_out[i] = org_q;
  end
endmodule : poc_top

//--- dv/poc_properties.sv
`timescale 1ns/10ps
module poc_properties (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // requests
  input wire logic ctrl_wr_in,
  input wire logic [1:0] ctrl_wr_sel_in,
  input wire logic [15:0] ctrl_wr_data_in,
  input wire logic [1:0] ctrl_rd_sel_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_chan_in,
  input wire logic [2:0] cmd_op_in,
  input wire logic cmd_cw_in,
  input wire logic block_op_busy_in,
  // answers
  input wire logic [15:0] ctrl_rd_data_out,
  input wire logic pos_rd_valid_out,
  input wire logic [3:0] pulse_out,
  input wire logic [3:0] dir_out,
  input wire logic [3:0] busy_out,
  input wire logic [3:0] origin_defined_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic rd_req;
  logic jog_req;
  assign rd_req = cmd_valid_in && cmd_op_in == 3'h6;
  assign jog_req = cmd_valid_in && cmd_op_in inside {3'h1, 3'h2, 3'h7};
  property p_readback;
    ctrl_wr_in && ctrl_rd_sel_in == ctrl_wr_sel_in ##1 $stable(ctrl_rd_sel_in)
      |=> ctrl_rd_data_out == $past(ctrl_wr_data_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("word readback wrong");
  property p_jog_starts;
    cmd_valid_in && cmd_op_in == 3'h1 && cmd_chan_in == 2'h2 |-> ##2 busy_out[2];
  endproperty
  a_jog_starts: assert property (p_jog_starts) else $error("jog not started");
  property p_dir;
    jog_req |-> ##2 dir_out[$past(cmd_chan_in, 2)] == $past(cmd_cw_in, 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction level wrong");
  property p_load_defines;
    cmd_valid_in && cmd_op_in == 3'h5 |-> ##2 origin_defined_out[$past(cmd_chan_in, 2)];
  endproperty
  a_load_defines: assert property (p_load_defines) else $error("origin not set");
  property p_read_answer;
    rd_req |-> ##[1:2] pos_rd_valid_out;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_cause;
    pos_rd_valid_out |-> $past(rd_req) || $past(rd_req, 2);
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("read answer unasked");
  property p_return_refused;
    cmd_valid_in && cmd_op_in == 3'h4 && origin_defined_out == 4'h0 && busy_out == 4'h0
      |-> ##2 busy_out == 4'h0;
  endproperty
  a_return_refused: assert property (p_return_refused) else $error("return ran");
  property p_pause;
    block_op_busy_in [*3] |-> $stable(pulse_out);
  endproperty
  a_pause: assert property (p_pause) else $error("pulses during block op");
  property p_idle_low;
    (busy_out == 4'h0) [*3] |-> pulse_out == 4'h0;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("pulse while idle");
  c_home: cover property ($rose(origin_defined_out[1]));
  c_read: cover property (pos_rd_valid_out);
  c_pause: cover property (block_op_busy_in && busy_out[3]);
endmodule : poc_properties

bind poc_top poc_properties poc_properties_inst (.core_clk_in, .rst_n_in, .ctrl_wr_in,
  .ctrl_wr_sel_in, .ctrl_wr_data_in, .ctrl_rd_sel_in, .cmd_valid_in, .cmd_chan_in,
  .cmd_op_in, .cmd_cw_in, .block_op_busy_in, .ctrl_rd_data_out, .pos_rd_valid_out,
  .pulse_out, .dir_out, .busy_out, .origin_defined_out);

//--- dv/poc_drive_model.sv
`timescale 1ns/10ps
module poc_drive_model #(
  parameter int PROX_AT = 8,
  parameter int ORG_DELAY = 30
) (
  // clock
  input wire logic clk_in,
  // drive inputs
  input wire logic [3:0] pulse_in,
  input wire logic [3:0] dir_in,
  // sensors
  output logic [3:0] prox_out,
  output logic [3:0] origin_out
);
  int cnt [4];
  int dly [4];
  logic [3:0] pulse_q;
  initial begin
    prox_out = 4'h0;
    origin_out = 4'h0;
    pulse_q = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cnt[i] = 0;
      dly[i] = 0;
    end
  end
  // origin mark comes a while after the proximity sensor, like an encoder index
  always @(posedge clk_in) begin
    pulse_q <= pulse_in;
    for (int i = 0; i < 4; i++) begin
      if (pulse_in[i] && !pulse_q[i]) cnt[i] <= dir_in[i] ? cnt[i] + 1 : cnt[i] - 1;
      prox_out[i] <= cnt[i] >= PROX_AT;
      dly[i] <= prox_out[i] ? dly[i] + 1 : 0;
      origin_out[i] <= dly[i] == ORG_DELAY;
    end
  end
endmodule : poc_drive_model

//--- dv/poc_top_test.sv
`timescale 1ns/10ps
module poc_top_test;
  logic core_clk_in, rst_n_in, ctrl_wr_in, cmd_valid_in, cmd_cw_in, block_op_busy_in;
  logic pos_rd_valid_out;
  logic [1:0] ctrl_wr_sel_in, ctrl_rd_sel_in, cmd_chan_in;
  logic [2:0] cmd_op_in;
  logic [3:0] feed_int_in, origin_in, origin_prox_in, pulse_out, dir_out, busy_out;
  logic [3:0] origin_defined_out;
  logic [15:0] ctrl_wr_data_in, ctrl_rd_data_out;
  logic [19:0] cmd_freq_in, cmd_accel_in;
  logic [31:0] cmd_value_in, pos_rd_data_out;
  int err_count, compares, cycles, c0;
  localparam logic [19:0] F = 20'hf_4240;

  poc_top #(.CYCLE_CYCLES(20)) poc_top_inst (.core_clk_in, .rst_n_in, .ctrl_wr_in,
    .ctrl_wr_sel_in, .ctrl_wr_data_in, .ctrl_rd_sel_in, .ctrl_rd_data_out, .cmd_valid_in,
    .cmd_chan_in, .cmd_op_in, .cmd_freq_in, .cmd_accel_in, .cmd_value_in, .cmd_cw_in,
    .block_op_busy_in, .pos_rd_valid_out, .pos_rd_data_out, .origin_in, .origin_prox_in,
    .feed_int_in, .pulse_out, .dir_out, .busy_out, .origin_defined_out);
  poc_drive_model poc_drive_model_inst (.clk_in(core_clk_in), .pulse_in(pulse_out),
    .dir_in(dir_out), .prox_out(origin_prox_in), .origin_out(origin_in));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic wr_ctrl(input logic [1:0] ch, input logic [15:0] d);
    @(posedge core_clk_in);
    ctrl_wr_in <= 1'b1;
    ctrl_wr_sel_in <= ch;
    ctrl_rd_sel_in <= ch;
    ctrl_wr_data_in <= d;
    @(posedge core_clk_in);
    ctrl_wr_in <= 1'b0;
  endtask : wr_ctrl

  task automatic rd_ctrl(input logic [1:0] ch, input logic [15:0] exp);
    @(posedge core_clk_in);
    ctrl_rd_sel_in <= ch;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("ctrl", {16'h0, exp}, {16'h0, ctrl_rd_data_out});
  endtask : rd_ctrl

  task automatic cmd(input logic [1:0] ch, input logic [2:0] op, input logic [19:0] a,
    input logic [31:0] v, input logic cw);
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b1;
    cmd_chan_in <= ch;
    cmd_op_in <= op;
    cmd_accel_in <= a;
    cmd_value_in <= v;
    cmd_cw_in <= cw;
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask : cmd

  task automatic rd_pos(input logic [1:0] ch, input logic [31:0] exp);
    cmd(ch, 3'h6, 20'h0, 32'h0, 1'b0);
    chk("pos", exp, pos_rd_data_out);
  endtask : rd_pos

  task automatic wait_idle(input logic [1:0] ch, input int n);
    for (int k = 0; k < n && busy_out[ch] !== 1'b0; k++) @(posedge core_clk_in);
    #1;
    chk("idle", 32'h0, {31'h0, busy_out[ch]});
  endtask : wait_idle

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // ceiling well above the few thousand cycles the sequence needs
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("unexpected timeout expected done seen running");
      finish_test();
    end
  end

  initial begin
    {rst_n_in, ctrl_wr_in, cmd_valid_in, cmd_cw_in, block_op_busy_in} = 5'h00;
    {ctrl_wr_sel_in, ctrl_rd_sel_in, cmd_chan_in, cmd_op_in} = 9'h000;
    {feed_int_in, ctrl_wr_data_in, cmd_accel_in, cmd_value_in} = 72'h0;
    cmd_freq_in = F;
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    for (int i = 0; i < 4; i++) wr_ctrl(2'(i), 16'hf0f0 + 16'(2 * i));
    for (int i = 0; i < 4; i++) rd_ctrl(2'(i), 16'hf0f0 + 16'(2 * i));
    for (int i = 0; i < 4; i++) wr_ctrl(2'(i), 16'h0000);
    cmd(2'h1, 3'h4, 20'h0, 32'h0, 1'b1);
    chk("refused", 32'h0, {28'h0, busy_out});
    cmd(2'h0, 3'h5, 20'h0, 32'h0000_0123, 1'b0);
    chk("defined", 32'h1, {31'h0, origin_defined_out[0]});
    rd_pos(2'h0, 32'h0000_0123);
    cmd(2'h0, 3'h4, 20'h0, 32'h0, 1'b1);
    chk("return", 32'h2, {30'h0, busy_out[0], dir_out[0]});
    repeat (400) @(posedge core_clk_in);
    cmd(2'h0, 3'h0, 20'h0, 32'h0, 1'b0);
    wait_idle(2'h0, 100);
    rd_pos(2'h0, 32'(291 + poc_drive_model_inst.cnt[0]));
    wr_ctrl(2'h0, 16'h0001);
    repeat (50) @(posedge core_clk_in);
    rd_pos(2'h0, 32'h0);
    wr_ctrl(2'h0, 16'h0000);
    c0 = poc_drive_model_inst.cnt[0];
    cmd(2'h0, 3'h2, F, 32'h0, 1'b1);
    repeat (300) @(posedge core_clk_in);
    chk("ramp", 32'h1, {31'h0, poc_drive_model_inst.cnt[0] > c0});
    wr_ctrl(2'h0, 16'h0100);
    wait_idle(2'h0, 30);
    wr_ctrl(2'h0, 16'h0000);
    cmd(2'h2, 3'h1, 20'h0, 32'h0, 1'b1);
    repeat (300) @(posedge core_clk_in);
    wr_ctrl(2'h2, 16'h0001);
    repeat (50) @(posedge core_clk_in);
    cmd(2'h2, 3'h0, 20'h0, 32'h0, 1'b0);
    wait_idle(2'h2, 100);
    rd_pos(2'h2, 32'(poc_drive_model_inst.cnt[2]));
    wr_ctrl(2'h2, 16'h0000);
    cmd(2'h1, 3'h3, 20'h0, 32'h0, 1'b1);
    wait_idle(2'h1, 3000);
    chk("home", 32'h1, {31'h0, origin_defined_out[1]});
    rd_pos(2'h1, 32'h0);
    // gentle ramp so the feed tail ends in a few hundred cycles, not at creep
    cmd(2'h3, 3'h7, 20'h0_61a8, 32'h2, 1'b0);
    chk("feed", 32'h2, {30'h0, busy_out[3], dir_out[3]});
    repeat (200) @(posedge core_clk_in);
    block_op_busy_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    c0 = poc_drive_model_inst.cnt[3];
    repeat (300) @(posedge core_clk_in);
    chk("paused", 32'(c0), 32'(poc_drive_model_inst.cnt[3]));
    block_op_busy_in <= 1'b0;
    repeat (300) @(posedge core_clk_in);
    chk("resumed", 32'h1, {31'h0, poc_drive_model_inst.cnt[3] < c0});
    // interrupt during a pause so no pulse slips in before the count starts
    block_op_busy_in <= 1'b1;
    feed_int_in <= 4'h8;
    repeat (6) @(posedge core_clk_in);
    c0 = poc_drive_model_inst.cnt[3];
    block_op_busy_in <= 1'b0;
    wait_idle(2'h3, 2000);
    chk("fed", 32'(c0 - 2), 32'(poc_drive_model_inst.cnt[3]));
    feed_int_in <= 4'h0;
    finish_test();
  end
endmodule : poc_top_test
